//--- shared/fspc_params.svh
// Constants of the flash self-programming controller: offsets, fields, reset values, timing
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH

// ************************************************************
// Register offsets on the software port
// ************************************************************
`define FSPC_OFS_ADDR_LOW   3'h0
`define FSPC_OFS_ADDR_HIGH  3'h1
`define FSPC_OFS_DATA_LOW   3'h2
`define FSPC_OFS_DATA_HIGH  3'h3
`define FSPC_OFS_CTRL       3'h4
`define FSPC_OFS_KEY        3'h5

// ************************************************************
// Control register field positions
// ************************************************************
`define FSPC_CTRL_RD        0
`define FSPC_CTRL_WR        1
`define FSPC_CTRL_WRITE_ENABLE_GATE      2
`define FSPC_CTRL_WRITE_ABORT_FLAG     3
`define FSPC_CTRL_ERASE     4
`define FSPC_CTRL_LOAD_ONLY 5

// ************************************************************
// Reset values, keys and protection boundaries
// ************************************************************
`define FSPC_LATCH_RST      14'h3FFF
`define FSPC_ADDR_RST       15'h0000
`define FSPC_DATA_RST       14'h0000
`define FSPC_KEY_FIRST      8'h55
`define FSPC_KEY_SECOND     8'hAA
`define FSPC_WP_HALF_TOP    15'h4000
`define FSPC_WP_BOOT_TOP    15'h0200

// ************************************************************
// Timing: clock period, row erase or program duration, setup count
// ************************************************************
`define FSPC_CLK_PERIOD_PS  5000
`define FSPC_OP_TIME_US     2000
`define FSPC_SETUP_CYC      2'h1

`endif

//--- shared/fspc_pkg.sv
// Types of the flash self-programming controller
package fspc_pkg;

	// Sequencer states, Gray coded along the read path
	typedef enum logic [2:0]
	{
		FSPC_IDLE     = 3'h0,
		FSPC_RD_WAIT  = 3'h1,
		FSPC_RD_ISSUE = 3'h3,
		FSPC_RD_CAP   = 3'h2,
		FSPC_WR_SETUP = 3'h6,
		FSPC_WR_BUSY  = 3'h7
	} fspc_state_t;

	// Unlock key recognition progress
	typedef enum logic [1:0]
	{
		FSPC_KEY_NONE = 2'h0,
		FSPC_KEY_GOT1 = 2'h1,
		FSPC_KEY_GOT2 = 2'h3
	} fspc_key_t;

	typedef logic [13:0] fspc_word_t;
	typedef logic [14:0] fspc_addr_t;

endpackage : fspc_pkg

//--- design/fspc_sync3.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module fspc_sync3
#(
	parameter int W = 2
)
(
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// ************************************************************
	// Per-bit chain; a change counts once stages two and three agree
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++)
		begin : g_bit
			always_ff @(posedge mclk or posedge sys_rst)
			begin
				if (sys_rst)
				begin
					s1_r[gi]      <= 1'b0;
					s2_r[gi]      <= 1'b0;
					s3_r[gi]      <= 1'b0;
					level_out[gi] <= 1'b0;
				end
				else
				begin
					s1_r[gi] <= pin_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					// Hold last agreed level while stages disagree
					if (s2_r[gi] == s3_r[gi])
						level_out[gi] <= s3_r[gi];
				end
			end
		end
	endgenerate

endmodule : fspc_sync3

//--- design/fspc_latches.sv
// Row of 32 write latches, 14 bits each, reset to the erased pattern
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_latches
(
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	input  wire logic                 clr,
	input  wire logic                 ld,
	input  wire logic [4:0]           ld_idx,
	input  wire fspc_pkg::fspc_word_t ld_data,
	output logic      [447:0]         row_data
);

	// ************************************************************
	// One latch per word; clear outranks load in the same cycle
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++)
		begin : g_latch
			always_ff @(posedge mclk or posedge sys_rst)
			begin
				if (sys_rst)
					row_data[gi*14 +: 14] <= `FSPC_LATCH_RST;
				else if (clr)
					row_data[gi*14 +: 14] <= `FSPC_LATCH_RST;
				else if (ld && (ld_idx == 5'(gi)))
					row_data[gi*14 +: 14] <= ld_data;
			end
		end
	endgenerate

endmodule : fspc_latches

//--- design/fspc_ctrl.sv
// Flash self-programming controller: registers, unlock, sequencer, protection
//
// Overview of operation
// - Data pair holds one 14-bit word
// - Address pair holds one 15-bit word address
// - Address high byte upper bits, low byte lower
// - Software can only set start bits
// - Hardware clears start bits at completion
// - Erase or write only with write-enable gate
// - Write-enable gate clear at power-up
// - Reset during write sets sticky abort flag
// - Key register reads back as zero
// - Key pattern required before latch or flash change
// - Internal timer sets erase and write duration
// - Erase always covers one 32-word row
// - Writes staged in 32 hidden 14-bit latches
// - Code protect denies external programmer access only
// - Only external bulk erase lifts code protection
// - Write-protect field blocks self-write of region
// - Unwritten words programmable without prior erase
// - Read uses second cycle, data one later
// - Row erase or program stalls processor 2 ms
// - Completed program resets latches to 3FFF
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "fspc_params.svh"
module fspc_ctrl
#(
	parameter int OP_CYC = (`FSPC_OP_TIME_US * 1000000) / `FSPC_CLK_PERIOD_PS
)
(
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	input  wire logic                 dev_soft_rst,
	input  wire logic [2:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	input  wire logic                 code_protect_n,
	input  wire logic [1:0]           self_write_protect_sel,
	input  wire logic                 ext_access_pin,
	input  wire logic                 ext_bulk_erase_pin,
	output logic                      ext_access_grant,
	output logic                      flash_bulk_erase,
	output fspc_pkg::fspc_addr_t      flash_addr,
	output logic                      flash_rd,
	input  wire fspc_pkg::fspc_word_t flash_rdata,
	output logic                      flash_erase,
	output logic                      flash_prog,
	output logic      [447:0]         flash_row_data,
	output logic                      cpu_stall
);

	// ************************************************************
	// Declarations
	// ************************************************************
	fspc_pkg::fspc_state_t state_r;
	fspc_pkg::fspc_key_t   key_r;
	fspc_pkg::fspc_addr_t  addr_r;
	fspc_pkg::fspc_word_t  data_r;
	logic [19:0]           cnt_r;
	logic                  read_start_r;
	logic                  write_start_r;
	logic                  write_enable_gate_r;
	logic                  write_abort_flag_r;
	logic                  erase_sel_r;
	logic                  load_only_r;
	logic                  latch_ld_r;
	logic                  latch_clr_r;
	logic                  bulk_prev_r;
	logic [1:0]            pin_lvl;

	localparam logic [19:0] OP_LAST = 20'(OP_CYC - 1);

	// Self-write protection decode, used for erase and program alike
	function automatic logic wp_blocked(input logic [1:0] sel, input fspc_pkg::fspc_addr_t a);
		case (sel)
			2'h3:    wp_blocked = 1'b0;
			2'h2:    wp_blocked = (a < `FSPC_WP_BOOT_TOP);
			2'h1:    wp_blocked = (a < `FSPC_WP_HALF_TOP);
			default: wp_blocked = 1'b1;
		endcase
	endfunction : wp_blocked

	// ************************************************************
	// Bus decode and unlock conditions
	// ************************************************************
	wire wr_alow  = reg_wr && (reg_addr == `FSPC_OFS_ADDR_LOW);
	wire wr_ahigh = reg_wr && (reg_addr == `FSPC_OFS_ADDR_HIGH);
	wire wr_dlow  = reg_wr && (reg_addr == `FSPC_OFS_DATA_LOW);
	wire wr_dhigh = reg_wr && (reg_addr == `FSPC_OFS_DATA_HIGH);
	wire wr_ctrl  = reg_wr && (reg_addr == `FSPC_OFS_CTRL);
	wire wr_key   = reg_wr && (reg_addr == `FSPC_OFS_KEY);
	wire idle     = (state_r == fspc_pkg::FSPC_IDLE);
	wire start_rd = wr_ctrl && reg_wdata[`FSPC_CTRL_RD] && idle;
	// Start is honoured only right after the two keys and only when idle
	wire start_wr = wr_ctrl && reg_wdata[`FSPC_CTRL_WR] && idle && (key_r == fspc_pkg::FSPC_KEY_GOT2);
	wire op_ok    = write_enable_gate_r && !wp_blocked(self_write_protect_sel, addr_r);
	wire setup_end = (state_r == fspc_pkg::FSPC_WR_SETUP) && (cnt_r[1:0] == `FSPC_SETUP_CYC);
	wire busy_end  = (state_r == fspc_pkg::FSPC_WR_BUSY) && (cnt_r == OP_LAST);
	wire pin_bulk  = pin_lvl[1];

	// Read data selection; key register and unused offsets read zero
	wire [7:0] ctrl_view = {2'h0, load_only_r, erase_sel_r, write_abort_flag_r, write_enable_gate_r, write_start_r, read_start_r};
	wire [7:0] rd_mux =
		(reg_addr == `FSPC_OFS_ADDR_LOW)  ? addr_r[7:0] :
		(reg_addr == `FSPC_OFS_ADDR_HIGH) ? {1'b0, addr_r[14:8]} :
		(reg_addr == `FSPC_OFS_DATA_LOW)  ? data_r[7:0] :
		(reg_addr == `FSPC_OFS_DATA_HIGH) ? {2'h0, data_r[13:8]} :
		(reg_addr == `FSPC_OFS_CTRL)      ? ctrl_view : 8'h00;

	// ************************************************************
	// Helper instances
	// ************************************************************
	fspc_sync3 #(.W(2)) u_sync
	(
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.pin_in    ({ext_bulk_erase_pin, ext_access_pin}),
		.level_out (pin_lvl)
	);

	fspc_latches u_latches
	(
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clr      (latch_clr_r),
		.ld       (latch_ld_r),
		.ld_idx   (addr_r[4:0]),
		.ld_data  (data_r),
		.row_data (flash_row_data)
	);

	// ************************************************************
	// Software-visible registers
	// ************************************************************
	// Read data register, valid the cycle after the read strobe
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// Address pair; row boundary is addr[14:5], latch index addr[4:0]
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			addr_r <= `FSPC_ADDR_RST;
		else if (dev_soft_rst)
			addr_r <= `FSPC_ADDR_RST;
		else if (wr_alow)
			addr_r[7:0] <= reg_wdata;
		else if (wr_ahigh)
			addr_r[14:8] <= reg_wdata[6:0];
	end

	// Data pair; a finished flash read overwrites software data
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			data_r <= `FSPC_DATA_RST;
		else if (dev_soft_rst)
			data_r <= `FSPC_DATA_RST;
		else if (state_r == fspc_pkg::FSPC_RD_CAP)
			data_r <= flash_rdata;
		else if (wr_dlow)
			data_r[7:0] <= reg_wdata;
		else if (wr_dhigh)
			data_r[13:8] <= reg_wdata[5:0];
	end

	// Control fields; only the abort flag survives device resets
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			write_enable_gate_r      <= 1'b0;
			write_abort_flag_r     <= 1'b0;
			erase_sel_r <= 1'b0;
			load_only_r <= 1'b0;
		end
		else if (dev_soft_rst)
		begin
			write_enable_gate_r      <= 1'b0;
			erase_sel_r <= 1'b0;
			load_only_r <= 1'b0;
			if (state_r == fspc_pkg::FSPC_WR_BUSY)
				write_abort_flag_r <= 1'b1;
		end
		else if (wr_ctrl)
		begin
			write_enable_gate_r      <= reg_wdata[`FSPC_CTRL_WRITE_ENABLE_GATE];
			write_abort_flag_r     <= reg_wdata[`FSPC_CTRL_WRITE_ABORT_FLAG];
			erase_sel_r <= reg_wdata[`FSPC_CTRL_ERASE];
			load_only_r <= reg_wdata[`FSPC_CTRL_LOAD_ONLY];
		end
	end

	// ************************************************************
	// Unlock key tracking
	// ************************************************************
	// Any write other than the next expected one or a first key drops the progress
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			key_r <= fspc_pkg::FSPC_KEY_NONE;
		else if (dev_soft_rst)
			key_r <= fspc_pkg::FSPC_KEY_NONE;
		else if (wr_key && (reg_wdata == `FSPC_KEY_FIRST))
			key_r <= fspc_pkg::FSPC_KEY_GOT1;
		else if (wr_key && (reg_wdata == `FSPC_KEY_SECOND) && (key_r == fspc_pkg::FSPC_KEY_GOT1))
			key_r <= fspc_pkg::FSPC_KEY_GOT2;
		else if (reg_wr)
			key_r <= fspc_pkg::FSPC_KEY_NONE;
	end

	// ************************************************************
	// Operation sequencer
	// ************************************************************
	// Start bits are set only by software and cleared only here
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r       <= fspc_pkg::FSPC_IDLE;
			cnt_r         <= 20'h00000;
			read_start_r  <= 1'b0;
			write_start_r <= 1'b0;
			flash_rd      <= 1'b0;
			flash_erase   <= 1'b0;
			flash_prog    <= 1'b0;
			latch_ld_r    <= 1'b0;
			latch_clr_r   <= 1'b0;
			cpu_stall     <= 1'b0;
		end
		else if (dev_soft_rst)
		begin
			state_r       <= fspc_pkg::FSPC_IDLE;
			cnt_r         <= 20'h00000;
			read_start_r  <= 1'b0;
			write_start_r <= 1'b0;
			flash_rd      <= 1'b0;
			flash_erase   <= 1'b0;
			flash_prog    <= 1'b0;
			latch_ld_r    <= 1'b0;
			latch_clr_r   <= 1'b0;
			cpu_stall     <= 1'b0;
		end
		else
		begin
			flash_erase <= 1'b0;
			flash_prog  <= 1'b0;
			latch_ld_r  <= 1'b0;
			latch_clr_r <= 1'b0;
			cnt_r       <= cnt_r + 20'h00001;
			case (state_r)
				fspc_pkg::FSPC_IDLE:
				begin
					cnt_r <= 20'h00000;
					if (start_wr)
					begin
						write_start_r <= 1'b1;
						cpu_stall     <= 1'b1;
						state_r       <= fspc_pkg::FSPC_WR_SETUP;
					end
					else if (start_rd)
					begin
						read_start_r <= 1'b1;
						state_r      <= fspc_pkg::FSPC_RD_WAIT;
					end
				end
				fspc_pkg::FSPC_RD_WAIT:
				begin
					flash_rd <= 1'b1;
					state_r  <= fspc_pkg::FSPC_RD_ISSUE;
				end
				fspc_pkg::FSPC_RD_ISSUE:
				begin
					flash_rd <= 1'b0;
					state_r  <= fspc_pkg::FSPC_RD_CAP;
				end
				fspc_pkg::FSPC_RD_CAP:
				begin
					read_start_r <= 1'b0;
					state_r      <= fspc_pkg::FSPC_IDLE;
				end
				fspc_pkg::FSPC_WR_SETUP:
				begin
					if (setup_end)
					begin
						cnt_r <= 20'h00000;
						if (!op_ok)
						begin
							write_start_r <= 1'b0;
							cpu_stall     <= 1'b0;
							state_r       <= fspc_pkg::FSPC_IDLE;
						end
						else if (load_only_r && !erase_sel_r)
						begin
							latch_ld_r    <= 1'b1;
							write_start_r <= 1'b0;
							cpu_stall     <= 1'b0;
							state_r       <= fspc_pkg::FSPC_IDLE;
						end
						else
						begin
							flash_erase <= erase_sel_r;
							flash_prog  <= !erase_sel_r;
							state_r     <= fspc_pkg::FSPC_WR_BUSY;
						end
					end
				end
				fspc_pkg::FSPC_WR_BUSY:
				begin
					if (busy_end)
					begin
						latch_clr_r   <= !erase_sel_r;
						write_start_r <= 1'b0;
						cpu_stall     <= 1'b0;
						state_r       <= fspc_pkg::FSPC_IDLE;
					end
				end
				default:
				begin
					state_r <= fspc_pkg::FSPC_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// External programmer gate
	// ************************************************************
	// Self-programming ignores code protection; only the outside port is gated
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ext_access_grant <= 1'b0;
			flash_bulk_erase <= 1'b0;
			bulk_prev_r      <= 1'b0;
		end
		else
		begin
			ext_access_grant <= pin_lvl[0] && code_protect_n;
			bulk_prev_r      <= pin_bulk;
			flash_bulk_erase <= pin_bulk && !bulk_prev_r;
		end
	end

	// Flash word address follows the address pair one cycle later
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			flash_addr <= `FSPC_ADDR_RST;
		else
			flash_addr <= addr_r;
	end

endmodule : fspc_ctrl

//--- verification/fspc_ctrl_props.sv
// Port-level assertions for the flash self-programming controller
`timescale 1ns/1ps
module fspc_ctrl_props
#(
	parameter int OP_CYC = 20
)
(
	input	wire logic			mclk,
	input	wire logic			sys_rst,
	input	wire logic			dev_soft_rst,
	input	wire logic [2:0]		reg_addr,
	input	wire logic [7:0]		reg_wdata,
	input	wire logic			reg_wr,
	input	wire logic			reg_rd,
	input	wire logic [7:0]		reg_rdata,
	input	wire logic			code_protect_n,
	input	wire logic			ext_access_grant,
	input	wire fspc_pkg::fspc_addr_t	flash_addr,
	input	wire logic			flash_rd,
	input	wire logic			flash_erase,
	input	wire logic			flash_prog,
	input	wire logic [447:0]		flash_row_data,
	input	wire logic			cpu_stall
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic [31:0]	len_r;
	logic		k1_r;
	logic		k2_r;
	logic		armed_r;
	logic		prog_r;
	wire		key_wr = reg_wr && reg_addr == 3'h5;
	wire		arm = reg_wr && reg_addr == 3'h4 && reg_wdata[1] && k2_r;
	wire		op = flash_erase || flash_prog;

	// Stall length, key history and pending operation; key history only moves on writes
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			len_r <= 32'h0;
			k1_r <= 1'h0;
			k2_r <= 1'h0;
			armed_r <= 1'h0;
			prog_r <= 1'h0;
		end
		else
		begin
			len_r <= cpu_stall ? len_r + 32'h1 : 32'h0;
			if (reg_wr)
				k1_r <= key_wr && reg_wdata == 8'h55;
			if (reg_wr)
				k2_r <= k1_r && key_wr && reg_wdata == 8'hAA;
			armed_r <= arm || (armed_r && cpu_stall);
			prog_r <= flash_prog || (prog_r && cpu_stall);
		end

	rd_timing_a: assert property (flash_rd |-> $past(reg_wr && reg_addr == 3'h4 && reg_wdata[0], 2))
		else $error("flash read not two cycles after read start");
	op_setup_a: assert property (op |-> $past(cpu_stall) && $past(cpu_stall, 2) && !$past(cpu_stall, 3))
		else $error("erase or program without two setup cycles");
	stall_len_a: assert property ($fell(cpu_stall) && !$past(dev_soft_rst) |-> len_r == 2 || len_r == OP_CYC + 2)
		else $error("stall length not set by the internal timer");
	grant_protect_a: assert property (!code_protect_n && $past(!code_protect_n) |-> !ext_access_grant)
		else $error("external access granted while protected");
	key_zero_a: assert property (reg_rd && reg_addr == 3'h5 |=> reg_rdata == 8'h00)
		else $error("key register read not zero");
	addr_follow_a: assert property (reg_wr && reg_addr == 3'h0 |=> ##1 flash_addr[7:0] == $past(reg_wdata, 2))
		else $error("low address byte not forwarded");
	unlock_need_a: assert property (op |-> armed_r)
		else $error("flash changed without unlock sequence");
	latch_reset_a: assert property ($fell(cpu_stall) && prog_r && !$past(dev_soft_rst)
		|-> ##[0:2] flash_row_data == {32{14'h3FFF}})
		else $error("latches not erased after program");

	cover property (flash_rd);
	cover property (flash_erase);
	cover property (flash_prog);
endmodule : fspc_ctrl_props

bind fspc_ctrl fspc_ctrl_props #(.OP_CYC(OP_CYC)) fspc_ctrl_props_inst (.mclk, .sys_rst, .dev_soft_rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .code_protect_n, .ext_access_grant, .flash_addr, .flash_rd,
	.flash_erase, .flash_prog, .flash_row_data, .cpu_stall);

//--- verification/fspc_flash_model.sv
// Behavioural flash array standing behind the controller
`timescale 1ns/1ps
module fspc_flash_model
(
	input	wire logic			mclk,
	input	wire logic			sys_rst,
	input	wire fspc_pkg::fspc_addr_t	flash_addr,
	input	wire logic			flash_rd,
	input	wire logic			flash_erase,
	input	wire logic			flash_prog,
	input	wire logic			flash_bulk_erase,
	input	wire logic [447:0]		flash_row_data,
	output	fspc_pkg::fspc_word_t		flash_rdata,
	output	logic [7:0]			erase_cnt,
	output	logic [7:0]			prog_cnt,
	output	logic [7:0]			bulk_cnt,
	output	fspc_pkg::fspc_addr_t		last_addr,
	output	logic [447:0]			last_row
);
	// Read answers one cycle later; otherwise the bus toggles so stale data never looks valid
	// data after read cycle
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
			flash_rdata <= 14'h0;
		else
			flash_rdata <= flash_rd ? (flash_addr[13:0] ^ 14'h2A5C) : ~flash_rdata;

	// Operation log for the bench
	always_ff @(posedge mclk or posedge sys_rst)
		if (sys_rst)
		begin
			erase_cnt <= 8'h0;
			prog_cnt <= 8'h0;
			bulk_cnt <= 8'h0;
			last_addr <= 15'h0;
			last_row <= 448'h0;
		end
		else
		begin
			erase_cnt <= erase_cnt + {7'h0, flash_erase};
			prog_cnt <= prog_cnt + {7'h0, flash_prog};
			bulk_cnt <= bulk_cnt + {7'h0, flash_bulk_erase};
			if (flash_erase || flash_prog)
				last_addr <= flash_addr;
			if (flash_prog)
				last_row <= flash_row_data;
		end
endmodule : fspc_flash_model

//--- verification/flash_self_program_ctrl_tb.sv
// Register-level testbench for the flash self-programming controller
`timescale 1ns/1ps
module flash_self_program_ctrl_tb;
	logic			mclk = 1'h0;
	logic			sys_rst = 1'h1;
	logic			dev_soft_rst = 1'h0;
	logic [2:0]		reg_addr = 3'h0;
	logic [7:0]		reg_wdata = 8'h00;
	logic			reg_wr = 1'h0;
	logic			reg_rd = 1'h0;
	logic [7:0]		reg_rdata;
	logic			code_protect_n = 1'h0;
	logic [1:0]		self_write_protect_sel = 2'h3;
	logic			ext_access_pin = 1'h1;
	logic			ext_bulk_erase_pin = 1'h0;
	logic			ext_access_grant;
	logic			flash_bulk_erase;
	logic			flash_rd;
	logic			flash_erase;
	logic			flash_prog;
	logic			cpu_stall;
	fspc_pkg::fspc_addr_t	flash_addr;
	fspc_pkg::fspc_addr_t	last_addr;
	fspc_pkg::fspc_word_t	flash_rdata;
	logic [447:0]		flash_row_data;
	logic [447:0]		last_row;
	logic [7:0]		erase_cnt;
	logic [7:0]		prog_cnt;
	logic [7:0]		bulk_cnt;
	int			n_fail = 0;
	int			n_compared = 0;

	// Short operation timer keeps the run brief
	fspc_ctrl #(.OP_CYC(20)) fspc_ctrl_inst (.mclk, .sys_rst, .dev_soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .code_protect_n, .self_write_protect_sel, .ext_access_pin, .ext_bulk_erase_pin,
		.ext_access_grant, .flash_bulk_erase, .flash_addr, .flash_rd, .flash_rdata, .flash_erase, .flash_prog,
		.flash_row_data, .cpu_stall);
	fspc_flash_model fspc_flash_model_inst (.mclk, .sys_rst, .flash_addr, .flash_rd, .flash_erase, .flash_prog,
		.flash_bulk_erase, .flash_row_data, .flash_rdata, .erase_cnt, .prog_cnt, .bulk_cnt, .last_addr, .last_row);

	// Clock at 200 MHz
	initial
		forever #2.5 mclk = ~mclk;

	task automatic end_sim;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: observed %h, expected %h", $time, got, exp);
		end
	endtask : cmp_val

	// One-cycle write strobe, dropped after the taking edge
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		cmp_reg(v, exp);
	endtask : chk

	// key pair then start, nothing in between
	task automatic unlock_op(input logic [7:0] c);
		wr(3'h5, 8'h55);
		wr(3'h5, 8'hAA);
		wr(3'h4, c);
	endtask : unlock_op

	// Polls both start bits under a bound
	task automatic wait_idle;
		logic [7:0] v;
		int i;
		for (i = 0; i < 80; i++)
		begin
			rd(3'h4, v);
			if (v[1:0] === 2'h0)
				break;
		end
		if (i == 80)
		begin
			n_fail++;
			$display("wrong value at %0t: operation never finished", $time);
			end_sim;
		end
	endtask : wait_idle

	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note

	initial
	begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'h0;
		chk(3'h4, 8'h00);
		chk(3'h5, 8'h00);
		chk(3'h6, 8'h00);
		note("reset");
		wr(3'h0, 8'hA5);
		wr(3'h1, 8'hFF);
		chk(3'h1, 8'h7F);
		chk(3'h0, 8'hA5);
		note("address");
		// Model word is address xor 2A5C: 0123 gives 2B7F
		wr(3'h0, 8'h23);
		wr(3'h1, 8'h01);
		wr(3'h4, 8'h01);
		wait_idle;
		chk(3'h2, 8'h7F);
		chk(3'h3, 8'h2B);
		note("read");
		wr(3'h4, 8'h06);
		chk(3'h4, 8'h04);
		wr(3'h5, 8'h55);
		wr(3'h0, 8'h45);
		wr(3'h5, 8'hAA);
		wr(3'h4, 8'h16);
		wait_idle;
		cmp_val(16'(erase_cnt), 16'h0);
		unlock_op(8'h12);
		wait_idle;
		cmp_val(16'(erase_cnt), 16'h0);
		note("refusal");
		// Erase while code protected: self erase must still work
		wr(3'h0, 8'h45);
		wr(3'h1, 8'h0A);
		unlock_op(8'h16);
		wr(3'h4, 8'h14);
		chk(3'h4, 8'h16);
		cmp_val(16'(cpu_stall), 16'h1);
		wait_idle;
		cmp_val(16'(erase_cnt), 16'h1);
		cmp_val(16'(last_addr[14:5]), 16'h0052);
		note("erase");
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h01);
		for (int s = 0; s < 3; s++)
		begin
			self_write_protect_sel <= 2'(s);
			unlock_op(8'h16);
			wait_idle;
			cmp_val(16'(erase_cnt), 16'h1);
		end
		self_write_protect_sel <= 2'h3;
		note("protect");
		wr(3'h0, 8'h43);
		wr(3'h1, 8'h0A);
		wr(3'h2, 8'h34);
		wr(3'h3, 8'h12);
		unlock_op(8'h26);
		wait_idle;
		cmp_val(16'(flash_row_data[55:42]), 16'h1234);
		cmp_val(16'(flash_row_data[13:0]), 16'h3FFF);
		unlock_op(8'h06);
		wait_idle;
		cmp_val(16'(prog_cnt), 16'h1);
		cmp_val(16'(last_row[55:42]), 16'h1234);
		cmp_val(16'(flash_row_data === {32{14'h3FFF}}), 16'h1);
		note("program");
		// Device reset lands inside the busy phase
		unlock_op(8'h16);
		repeat (8) @(posedge mclk);
		dev_soft_rst <= 1'h1;
		@(posedge mclk);
		dev_soft_rst <= 1'h0;
		chk(3'h4, 8'h08);
		note("abort");
		repeat (10) @(posedge mclk);
		cmp_val(16'(ext_access_grant), 16'h0);
		code_protect_n <= 1'h1;
		ext_bulk_erase_pin <= 1'h1;
		repeat (10) @(posedge mclk);
		cmp_val(16'(ext_access_grant), 16'h1);
		cmp_val(16'(bulk_cnt), 16'h1);
		note("external");
		end_sim;
	end
endmodule : flash_self_program_ctrl_tb
